// [inc/vector_pkg.sv]
// Purpose: Shared constants and microcode for the vector line generator.
// Assumes: 12-bit datapath, 9-bit coordinates, 32-word microprogram.
// Notes: Register offsets are byte addresses on a 32-bit Wishbone bus.
package vector_pkg;

  // ************************************************************
  // Datapath and bank layout
  // ************************************************************
  localparam int DATA_W = 12;
  localparam int COORD_W = 9;
  localparam int WORD_ADDR_W = 14;
  localparam int BIT_SEL_W = 4;
  localparam int PARAM_DEPTH = 11;
  localparam int WORK_DEPTH = 5;
  localparam logic [3:0] IDX_Y = 4'h0;
  localparam logic [3:0] IDX_X = 4'h1;
  localparam logic [3:0] IDX_DOT_COUNT = 4'h2;
  localparam logic [3:0] IDX_DISC = 4'h3;
  localparam logic [3:0] IDX_OCT = 4'h4;
  localparam logic [3:0] IDX_OVF = 4'h5;
  localparam logic [3:0] IDX_XINC = 4'h6;
  localparam logic [3:0] IDX_YINC = 4'h7;
  localparam logic [3:0] IDX_DOTINC = 4'h8;
  localparam logic [3:0] IDX_STEP_NEG = 4'h9;
  localparam logic [3:0] IDX_STEP_POS = 4'ha;
  localparam logic [11:0] OVF_CONST = 12'he00;
  localparam logic [11:0] DOT_INC_CONST = 12'h001;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] PARAM_BASE = 8'h00;
  localparam logic [7:0] CTRL_OFS = 8'h40;
  localparam logic [7:0] STATUS_OFS = 8'h44;
  localparam logic [7:0] DOT_OFS = 8'h48;
  localparam int CTRL_DRAW_BIT = 0;
  localparam int CTRL_VALUE_BIT = 1;
  localparam logic CTRL_VALUE_RST = 1'b1;
  localparam logic [11:0] PARAM_RST = 12'h000;

  // ************************************************************
  // Microword layout and opcodes
  // ************************************************************
  localparam int UWORD_W = 16;
  localparam int PC_W = 5;
  localparam logic [PC_W-1:0] PC_START = 5'h00;
  localparam logic [7:0] OP_NOP = 8'h00;
  localparam logic [7:0] OP_CLRDRAW = 8'h01;
  localparam logic [7:0] OP_JND = 8'h02;
  localparam logic [7:0] OP_JMP = 8'h03;
  localparam logic [7:0] OP_JC = 8'h04;
  localparam logic [7:0] OP_JS = 8'h05;
  localparam logic [7:0] OP_LOAD = 8'h10;
  localparam logic [7:0] OP_ADD = 8'h11;
  localparam logic [7:0] OP_TEST = 8'h12;
  localparam logic [7:0] OP_STX = 8'h20;
  localparam logic [7:0] OP_STY = 8'h21;
  localparam logic [UWORD_W-1:0] UWORD_NOP = 16'h0000;

  typedef enum logic [1:0] {
    PH_DECODE = 2'b01,
    PH_WRITE = 2'b10
  } phase_t;

  typedef enum logic [2:0] {
    WR_IDLE = 3'b001,
    WR_SETUP = 3'b010,
    WR_PULSE = 3'b100
  } wr_state_t;

  // Low byte: working index in the high nibble, parameter index low
  function automatic logic [UWORD_W-1:0] ucode_rom(
    input logic [PC_W-1:0] pc
  );
    logic [UWORD_W-1:0] w;
    w = UWORD_NOP;
    case (pc)
      5'h00: w = {OP_CLRDRAW, 8'h00};
      5'h01: w = {OP_JND, 8'h01};
      5'h02: w = {OP_LOAD, 8'h00};
      5'h03: w = {OP_LOAD, 8'h11};
      5'h04: w = {OP_LOAD, 8'h22};
      5'h05: w = {OP_LOAD, 8'h33};
      5'h06: w = {OP_LOAD, 8'h44};
      5'h07: w = {OP_TEST, 8'h15};
      5'h08: w = {OP_JC, 8'h0d};
      5'h09: w = {OP_TEST, 8'h05};
      5'h0a: w = {OP_JC, 8'h0d};
      5'h0b: w = {OP_STX, 8'h00};
      5'h0c: w = {OP_STY, 8'h00};
      5'h0d: w = {OP_ADD, 8'h28};
      5'h0e: w = {OP_JC, 8'h00};
      5'h0f: w = {OP_TEST, 8'h4b};
      5'h10: w = {OP_JS, 8'h13};
      5'h11: w = {OP_ADD, 8'h16};
      5'h12: w = {OP_JMP, 8'h14};
      5'h13: w = {OP_ADD, 8'h07};
      5'h14: w = {OP_TEST, 8'h3b};
      5'h15: w = {OP_JS, 8'h1d};
      5'h16: w = {OP_ADD, 8'h3a};
      5'h17: w = {OP_TEST, 8'h4b};
      5'h18: w = {OP_JS, 8'h1b};
      5'h19: w = {OP_ADD, 8'h07};
      5'h1a: w = {OP_JMP, 8'h07};
      5'h1b: w = {OP_ADD, 8'h16};
      5'h1c: w = {OP_JMP, 8'h07};
      5'h1d: w = {OP_ADD, 8'h39};
      5'h1e: w = {OP_JMP, 8'h07};
      default: w = UWORD_NOP;
    endcase
    return w;
  endfunction : ucode_rom

endpackage : vector_pkg

// [verilog/adder_slices.sv]
// Purpose: 12-bit adder built from three 4-bit slices.
// Assumes: Purely combinational; caller latches the result.
// Notes: Sum leaves inverted, as the result latch expects.
`timescale 1ns/1ps
module adder_slices #(
  parameter int SLICES = 3
) (
  input wire logic [4*SLICES-1:0] a_i,
  input wire logic [4*SLICES-1:0] b_i,
  output logic [4*SLICES-1:0] sum_n_o,
  output logic carry_o
);
  logic [SLICES:0] c;
  assign c[0] = 1'b0;
  for (genvar s = 0; s < SLICES; s++) begin : g_slice
    logic [4:0] part;
    assign part = {1'b0, a_i[4*s +: 4]} + {1'b0, b_i[4*s +: 4]}
      + {4'h0, c[s]};
    assign sum_n_o[4*s +: 4] = ~part[3:0];
    assign c[s+1] = part[4];
  end
  assign carry_o = c[SLICES];
endmodule : adder_slices

// [verilog/vector_line_generator.sv]
// Purpose: Microsequenced incremental vector generator with dot writer.
// Assumes: One 50 MHz clock, synchronous active-high reset, Wishbone.
// Notes: Each microinstruction takes a decode and a write clock.
`timescale 1ns/1ps
module vector_line_generator (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [vector_pkg::WORD_ADDR_W-1:0] disp_addr_o,
  output logic [15:0] disp_bit_mask_o,
  output logic disp_bit_val_o,
  output logic disp_we_o
);
  import vector_pkg::*;

  // ************************************************************
  // Storage and sequencer state
  // ************************************************************
  logic [DATA_W-1:0] param_reg [0:PARAM_DEPTH-1];
  logic [DATA_W-1:0] work_reg [0:WORK_DEPTH-1];
  phase_t phase_reg;
  wr_state_t wr_reg;
  logic [PC_W-1:0] pc_reg;
  logic [UWORD_W-1:0] ir_reg, pre_ir_reg;
  logic [DATA_W-1:0] res_n_reg;
  logic block_reg, carry_reg, sign_reg, wb_pend_reg;
  logic [3:0] wb_idx_reg;
  logic [COORD_W-1:0] x_hold_reg, y_hold_reg;
  logic dot_req_reg, draw_reg, value_reg;
  logic [7:0] op;
  logic [3:0] wi, pi;
  logic [DATA_W-1:0] a_op, b_op, sum_n;
  logic carry, is_jump, cond, execute, jump_take, dot_take, bus_req;
  logic [5:0] wb_word;
  // Fixed entries read back as constants even when written, so software cannot break the check
  function automatic logic [DATA_W-1:0] param_read(input logic [3:0] idx);
    logic [DATA_W-1:0] v;
    v = '0;
    if (idx == IDX_OVF) begin
      v = OVF_CONST;
    end else if (idx == IDX_DOTINC) begin
      v = DOT_INC_CONST;
    end else if (idx < 4'(PARAM_DEPTH)) begin
      v = param_reg[idx];
    end
    return v;
  endfunction : param_read

  // ************************************************************
  // Decode
  // ************************************************************
  always_comb begin
    op = ir_reg[15:8];
    wi = ir_reg[7:4];
    pi = ir_reg[3:0];
    b_op = param_read(pi);
    a_op = '0;
    if (op != OP_LOAD && wi < 4'(WORK_DEPTH)) begin
      a_op = work_reg[wi[2:0]];
    end
    is_jump = (op == OP_JMP) || (op == OP_JC) || (op == OP_JS)
      || (op == OP_JND);
    unique case (op)
      OP_JMP: cond = 1'b1;
      OP_JC: cond = carry_reg;
      OP_JS: cond = sign_reg;
      OP_JND: cond = !draw_reg;
      default: cond = 1'b0;
    endcase
  end
  assign execute = (phase_reg == PH_DECODE) && !block_reg;
  assign jump_take = execute && is_jump && cond;
  assign dot_take = (wr_reg == WR_IDLE) && dot_req_reg;
  adder_slices #(
    .SLICES(3)
  ) u_adder (
    .a_i(a_op),
    .b_i(b_op),
    .sum_n_o(sum_n),
    .carry_o(carry)
  );
  // ************************************************************
  // Microsequencer
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_reg <= PH_DECODE;
    end else if (phase_reg == PH_DECODE) begin
      phase_reg <= PH_WRITE;
    end else begin
      phase_reg <= PH_DECODE;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_reg <= PC_START;
      ir_reg <= UWORD_NOP;
      pre_ir_reg <= UWORD_NOP;
      block_reg <= 1'b0;
    end else if (phase_reg == PH_DECODE) begin
      pre_ir_reg <= ucode_rom(pc_reg);
      if (jump_take) begin
        pc_reg <= ir_reg[PC_W-1:0];
        block_reg <= 1'b1;
      end else begin
        pc_reg <= pc_reg + 5'h01;
        block_reg <= 1'b0;
      end
    end else begin
      ir_reg <= pre_ir_reg;
    end
  end
  // Flags change only on add and test, so jumps see the last compare
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      res_n_reg <= '1;
      carry_reg <= 1'b0;
      sign_reg <= 1'b0;
      wb_pend_reg <= 1'b0;
      wb_idx_reg <= 4'h0;
    end else if (execute) begin
      wb_pend_reg <= (op == OP_ADD) || (op == OP_LOAD);
      wb_idx_reg <= wi;
      if (op == OP_ADD || op == OP_LOAD || op == OP_TEST) begin
        res_n_reg <= sum_n;
      end
      if (op == OP_ADD || op == OP_TEST) begin
        carry_reg <= carry;
        sign_reg <= ~sum_n[DATA_W-1];
      end
    end else if (phase_reg == PH_WRITE) begin
      wb_pend_reg <= 1'b0;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < WORK_DEPTH; i++) begin
        work_reg[i] <= '0;
      end
    end else if (phase_reg == PH_WRITE && wb_pend_reg
        && wb_idx_reg < 4'(WORK_DEPTH)) begin
      work_reg[wb_idx_reg[2:0]] <= ~res_n_reg;
    end
  end
  // Stores are reached only past both range jumps
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      x_hold_reg <= '0;
      y_hold_reg <= '0;
    end else if (execute && op == OP_STX) begin
      x_hold_reg <= work_reg[IDX_X[2:0]][COORD_W-1:0];
    end else if (execute && op == OP_STY) begin
      y_hold_reg <= work_reg[IDX_Y[2:0]][COORD_W-1:0];
    end
  end
  // A new store in the take cycle wins over the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dot_req_reg <= 1'b0;
    end else if (execute && op == OP_STY) begin
      dot_req_reg <= 1'b1;
    end else if (dot_take) begin
      dot_req_reg <= 1'b0;
    end
  end

  // ************************************************************
  // Display write machine
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_reg <= WR_IDLE;
      disp_addr_o <= '0;
      disp_bit_mask_o <= '0;
      disp_bit_val_o <= 1'b0;
      disp_we_o <= 1'b0;
    end else begin
      unique case (wr_reg)
        WR_IDLE: begin
          disp_we_o <= 1'b0;
          if (dot_req_reg) begin
            disp_addr_o <= {y_hold_reg, x_hold_reg[8:4]};
            disp_bit_mask_o <= 16'h0001 << x_hold_reg[3:0];
            disp_bit_val_o <= value_reg;
            wr_reg <= WR_SETUP;
          end
        end
        WR_SETUP: begin
          disp_we_o <= 1'b1;
          wr_reg <= WR_PULSE;
        end
        WR_PULSE: begin
          disp_we_o <= 1'b0;
          wr_reg <= WR_IDLE;
        end
        default: begin
          disp_we_o <= 1'b0;
          wr_reg <= WR_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // Wishbone slave
  // ************************************************************
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_word = wb_adr_i[7:2];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < PARAM_DEPTH; i++) begin
        param_reg[i] <= PARAM_RST;
      end
    end else if (bus_req && wb_we_i && wb_adr_i < 8'(4 * PARAM_DEPTH)) begin
      if (wb_sel_i[0]) begin
        param_reg[wb_word[3:0]][7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        param_reg[wb_word[3:0]][11:8] <= wb_dat_i[11:8];
      end
    end
  end
  // Host set wins over the microcode clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      draw_reg <= 1'b0;
      value_reg <= CTRL_VALUE_RST;
    end else if (bus_req && wb_we_i && wb_adr_i == CTRL_OFS
        && wb_sel_i[0]) begin
      value_reg <= wb_dat_i[CTRL_VALUE_BIT];
      if (wb_dat_i[CTRL_DRAW_BIT]) begin
        draw_reg <= 1'b1;
      end else if (execute && op == OP_CLRDRAW) begin
        draw_reg <= 1'b0;
      end
    end else if (execute && op == OP_CLRDRAW) begin
      draw_reg <= 1'b0;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (bus_req && !wb_we_i) begin
      wb_dat_o <= '0;
      if (wb_adr_i < 8'(4 * PARAM_DEPTH)) begin
        wb_dat_o <= {20'h00000, param_read(wb_word[3:0])};
      end else if (wb_adr_i == CTRL_OFS) begin
        wb_dat_o <= {30'h00000000, value_reg, draw_reg};
      end else if (wb_adr_i == STATUS_OFS) begin
        wb_dat_o <= {19'h00000, pc_reg, 4'h0, sign_reg, carry_reg,
          dot_req_reg, (pc_reg > 5'h02)};
      end else if (wb_adr_i == DOT_OFS) begin
        wb_dat_o <= {7'h00, y_hold_reg, 7'h00, x_hold_reg};
      end
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_load_copy: assert property (
    execute && op == OP_LOAD
    |-> ##2 work_reg[$past(wi[2:0], 2)] == $past(b_op, 2))
    else $error("load did not copy parameter");
  chk_range_carry: assert property (
    execute && op == OP_TEST && pi == IDX_OVF
    |=> carry_reg == ($past(a_op) >= 12'h200))
    else $error("range carry wrong");
  chk_flag_sign: assert property (
    execute && op == OP_ADD |=> sign_reg == ($past(a_op + b_op) >= 12'h800))
    else $error("sign flag wrong");
  chk_dot_count_exit: assert property (
    execute && op == OP_JC && ir_reg[4:0] == 5'h00 && carry_reg
    |=> pc_reg == PC_START)
    else $error("dot count exit missed");
  chk_jump_hold: assert property (
    execute && is_jump && !cond |=> pc_reg == $past(pc_reg) + 5'h01)
    else $error("jump taken without condition");
  chk_jump_block: assert property (
    jump_take |=> block_reg ##1 !execute ##1 !wb_pend_reg)
    else $error("prefetched word executed");
  chk_dot_request: assert property (
    execute && op == OP_STY |=> dot_req_reg)
    else $error("dot request not raised");
  chk_bit_select: assert property (
    $rose(disp_we_o) |-> $onehot(disp_bit_mask_o)
    && disp_bit_mask_o == 16'h0001 << x_hold_reg[3:0])
    else $error("bit mask wrong");
  chk_write_pulse: assert property (
    dot_take |=> !disp_we_o ##1 disp_we_o ##1 !disp_we_o)
    else $error("write pulse shape wrong");
  chk_reset_state: assert property (
    $fell(rst_i) |-> pc_reg == PC_START && !draw_reg && !dot_req_reg)
    else $error("reset state wrong");
  cov_draw_start: cover property (draw_reg && pc_reg == 5'h02);
  cov_dot_write: cover property ($rose(disp_we_o));
  cov_vector_done: cover property (jump_take && ir_reg[4:0] == 5'h00);
  cov_out_of_range: cover property (execute && op == OP_JC && carry_reg
    && ir_reg[4:0] == 5'h0d);
endmodule : vector_line_generator

// [verification/display_memory_model.sv]
// Purpose: Bit-mapped display memory seen from the dot write port.
// Assumes: One write strobe per dot, word address and one-hot bit mask.
// Notes: Contents survive reset, as a real frame store would.
`timescale 1ns/1ps
module display_memory_model (
  input wire logic clk_i,
  input wire logic [vector_pkg::WORD_ADDR_W-1:0] disp_addr_i,
  input wire logic [15:0] disp_bit_mask_i,
  input wire logic disp_bit_val_i,
  input wire logic disp_we_i
);
  import vector_pkg::*;
  logic [15:0] mem [0:(1<<WORD_ADDR_W)-1];
  int write_count;
  int bad_masks;

  initial begin
    write_count = 0;
    bad_masks = 0;
    foreach (mem[i]) mem[i] = 16'h0000;
  end

  // Only the selected bit may change; a wide mask would smear the word
  always @(posedge clk_i) begin
    if (disp_we_i === 1'b1) begin
      write_count++;
      if ($countones(disp_bit_mask_i) != 1) begin
        bad_masks++;
      end
      if (disp_bit_val_i === 1'b1) begin
        mem[disp_addr_i] <= mem[disp_addr_i] | disp_bit_mask_i;
      end else begin
        mem[disp_addr_i] <= mem[disp_addr_i] & ~disp_bit_mask_i;
      end
    end
  end
endmodule : display_memory_model

// [verification/vector_line_generator_test.sv]
// Purpose: Register and drawing test of the vector line generator.
// Assumes: Wishbone classic master, memory model on the dot port.
// Notes: Expected dots come from a stepping model kept in this bench.
`timescale 1ns/1ps
module vector_line_generator_test;
  import vector_pkg::*;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd, exp_dot;
  logic [WORD_ADDR_W-1:0] disp_addr_o;
  logic [15:0] disp_bit_mask_o;
  logic disp_bit_val_o, disp_we_o;
  logic [15:0] exp_mem [0:(1<<WORD_ADDR_W)-1];
  int failures, comparisons, exp_writes;

  vector_line_generator uut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .disp_addr_o(disp_addr_o),
    .disp_bit_mask_o(disp_bit_mask_o), .disp_bit_val_o(disp_bit_val_o),
    .disp_we_o(disp_we_o));

  display_memory_model mem_model (.clk_i(clk_i), .disp_addr_i(disp_addr_o),
    .disp_bit_mask_i(disp_bit_mask_o), .disp_bit_val_i(disp_bit_val_o),
    .disp_we_i(disp_we_o));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic conclude;
    $display("Counts: %0d comparisons, %0d failures", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // ************************************************************
  // Bus cycle: hold everything until ack is sampled high
  // ************************************************************
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) begin
      n++;
      if (n > 50) begin
        failures++;
        conclude();
      end
      @(posedge clk_i);
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb

  task automatic rd_check(input logic [7:0] a, input logic [31:0] exp,
                          input string what);
    wb(1'b0, a, 32'h0);
    check(what, exp, rd);
  endtask : rd_check

  // ************************************************************
  // Load a vector, predict its dots, draw it and compare
  // ************************************************************
  task automatic draw(input logic [11:0] y, x, n, disc, oct, xi, yi, sn,
                      sp, input logic val);
    logic [11:0] cy, cx, d;
    int i;
    wb(1'b1, 8'h00, {20'h0, y});
    wb(1'b1, 8'h04, {20'h0, x});
    wb(1'b1, 8'h08, {20'h0, 12'h000 - n});
    wb(1'b1, 8'h0c, {20'h0, disc});
    wb(1'b1, 8'h10, {20'h0, oct});
    wb(1'b1, 8'h18, {20'h0, xi});
    wb(1'b1, 8'h1c, {20'h0, yi});
    wb(1'b1, 8'h24, {20'h0, sn});
    wb(1'b1, 8'h28, {20'h0, sp});
    check("writes before draw", exp_writes, mem_model.write_count);
    cy = y;
    cx = x;
    d = disc;
    for (i = 0; i < n; i++) begin
      if (cx < 12'h200 && cy < 12'h200) begin
        exp_mem[{cy[8:0], cx[8:4]}][cx[3:0]] = val;
        exp_writes++;
        exp_dot = {7'h00, cy[8:0], 7'h00, cx[8:0]};
      end
      if (oct[11]) cy = cy + yi;
      else cx = cx + xi;
      if (d[11]) d = d + sn;
      else begin
        d = d + sp;
        if (oct[11]) cx = cx + xi;
        else cy = cy + yi;
      end
    end
    wb(1'b1, CTRL_OFS, {30'h0, val, 1'b1});
    for (i = 0; i < 1000; i++) begin
      wb(1'b0, CTRL_OFS, 32'h0);
      if (rd[0] === 1'b0) break;
    end
    if (i == 1000) begin
      failures++;
      conclude();
    end
    check("ctrl after draw", {30'h0, val, 1'b0}, rd);
    wb(1'b0, STATUS_OFS, 32'h0);
    check("busy and request", 32'h0, {30'h0, rd[1:0]});
    rd_check(DOT_OFS, exp_dot, "last held dot");
    check("dot writes", exp_writes, mem_model.write_count);
    check("bad masks", 0, mem_model.bad_masks);
    for (i = 0; i < (1 << WORD_ADDR_W); i++) begin
      if (mem_model.mem[i] !== exp_mem[i]) begin
        check("display word", exp_mem[i], mem_model.mem[i]);
        break;
      end
    end
    comparisons++;
  endtask : draw

  initial begin
    failures = 0;
    comparisons = 0;
    exp_writes = 0;
    exp_dot = 32'h0;
    foreach (exp_mem[i]) exp_mem[i] = 16'h0000;
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    rd = 32'h0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_check(CTRL_OFS, 32'h2, "ctrl reset");
    wb(1'b0, STATUS_OFS, 32'h0);
    check("status reset", 32'h0, {30'h0, rd[1:0]});
    rd_check(8'h00, 32'h0, "start y reset");
    rd_check(8'h14, 32'he00, "range constant");
    rd_check(8'h20, 32'h001, "dot increment");
    wb(1'b1, 8'h14, 32'h123);
    rd_check(8'h14, 32'he00, "range constant kept");
    wb(1'b1, 8'h80, 32'hffff_ffff);
    rd_check(8'h80, 32'h0, "unmapped");
    wb(1'b1, 8'h18, 32'h0000_0abc);
    rd_check(8'h18, 32'habc, "x increment");
    // Shallow X line across a word boundary
    draw(12'h010, 12'h01c, 12'h008, 12'hffe, 12'h000, 12'h001, 12'h001,
         12'h002, 12'hffc, 1'b1);
    // Y-major line running off the bottom and the right edge
    draw(12'h003, 12'h1fd, 12'h007, 12'h000, 12'h800, 12'h001, 12'hfff,
         12'h003, 12'hffe, 1'b1);
    // Same first line again with the clear value
    draw(12'h010, 12'h01c, 12'h008, 12'hffe, 12'h000, 12'h001, 12'h001,
         12'h002, 12'hffc, 1'b0);
    conclude();
  end
endmodule : vector_line_generator_test
